// ===== common/wdrst_pkg.sv
// Constants shared by the watchdog and reset-pin sequencer
package wdrst_pkg;
  // APB address width and register byte offsets
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFF_CAUSE = 8'h00;
  localparam logic [APB_AW-1:0] OFF_OPT1 = 8'h04;
  localparam logic [APB_AW-1:0] OFF_OPT2 = 8'h08;
  localparam logic [APB_AW-1:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [APB_AW-1:0] OFF_IRQ_MASK = 8'h10;
  // Two-value service sequence
  localparam logic [31:0] SERVICE_FIRST = 32'h0000_0055;
  localparam logic [31:0] SERVICE_SECOND = 32'h0000_00aa;
  // Reset cause field positions
  localparam int CAUSE_W = 7;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_PIN = 1;
  localparam int CAUSE_WDOG = 2;
  localparam int CAUSE_ILLEGAL_OPCODE_RESET = 3;
  localparam int CAUSE_ILLEGAL_ADDRESS_RESET = 4;
  localparam int CAUSE_LVD = 5;
  localparam int CAUSE_LOC = 6;
  // Option fields and reset values
  localparam logic [1:0] TSEL_OFF = 2'h0;
  localparam logic [1:0] TSEL_RST = 2'h3;
  localparam int OPT2_CLKSEL_BIT = 0;
  localparam int OPT2_WINEN_BIT = 1;
  localparam logic CLKSEL_RST = 1'h0;
  localparam logic WINEN_RST = 1'h0;
  // Interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_SVC_DONE = 0;
  localparam int IRQ_OPT_IGNORED = 1;
  localparam int IRQ_STRAY_SECOND = 2;
  localparam int IRQ_SEQ_DONE = 3;
  // Reset pin timing in bus cycles
  localparam int SEQ_CNT_W = 6;
  localparam logic [SEQ_CNT_W-1:0] RST_DRIVE_CYC = 6'h22;
  localparam logic [SEQ_CNT_W-1:0] RST_SAMPLE_CYC = 6'h26;
  // Sequencer states
  typedef enum logic [1:0] {SEQ_DRIVE, SEQ_SETTLE, SEQ_HOLD, SEQ_RUN} wdrst_seq_e;
endpackage : wdrst_pkg

// ===== common/wdrst_cnt_if.sv
// Link between the watchdog control logic and its timeout counter
interface wdrst_cnt_if;
  logic restart;
  logic tick;
  logic bus_sel;
  logic [1:0] tsel;
  logic timeout;
  logic in_window;
  modport ctrl (output restart, output tick, output bus_sel, output tsel,
    input timeout, input in_window);
  modport cnt (input restart, input tick, input bus_sel, input tsel,
    output timeout, output in_window);
endinterface : wdrst_cnt_if

// ===== rtl/wdrst_sync.sv
// Two-flop synchroniser for pin-level inputs
module wdrst_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First flop feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : wdrst_sync

// ===== rtl/wdrst_counter.sv
// Watchdog timeout counter with window detection
module wdrst_counter #(
  parameter int CNT_W = 18,
  parameter int LPO_E1 = 5,
  parameter int LPO_E2 = 8,
  parameter int LPO_E3 = 10,
  parameter int BUS_E1 = 13,
  parameter int BUS_E2 = 16,
  parameter int BUS_E3 = 18
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control link
  wdrst_cnt_if.cnt cif
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;
  int exp_sel;

  // Timeout exponent from clock source and timeout select
  always_comb
  begin
    exp_sel = LPO_E3;
    case ({cif.bus_sel, cif.tsel})
      3'h1: exp_sel = LPO_E1;
      3'h2: exp_sel = LPO_E2;
      3'h3: exp_sel = LPO_E3;
      3'h5: exp_sel = BUS_E1;
      3'h6: exp_sel = BUS_E2;
      3'h7: exp_sel = BUS_E3;
      default: exp_sel = LPO_E3;
    endcase
    last = {CNT_W{1'b1}} >> (CNT_W - exp_sel);
  end

  // Final quarter of the period
  assign cif.in_window = (cnt_q >= (last - (last >> 2)));

  // Count ticks; restart or disable clears, expiry pulses timeout
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      cif.timeout <= 1'b0;
    end
    else
    begin
      cif.timeout <= 1'b0;
      if (cif.restart || cif.tsel == wdrst_pkg::TSEL_OFF)
        cnt_q <= '0;
      else if (cif.tick)
      begin
        if (cnt_q == last)
        begin
          cnt_q <= '0;
          cif.timeout <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule : wdrst_counter

// ===== rtl/wdrst_top.sv
// Watchdog with service sequence, write-once options and reset-pin sequencer
// Summary of operation
// - Writing 0x0055 then 0x00AA to cause address restarts the timeout.
// - Any other value written to the cause address resets the device at once.
// - Service writes never alter the read-only reset cause contents.
// - Enabled watchdog not serviced before timeout forces a system reset.
// - Watchdog is enabled after every reset; zero timeout select disables it.
// - Clock select picks bus clock or 1 kHz; three timeouts per source.
// - Reset default is 1 kHz source and longest timeout of 2^10 cycles.
// - Bus clock with window enabled: service only in last quarter, else reset.
// - No windowed servicing while the 1 kHz source drives the counter.
// - Counter starts on any reset and first option writes; later writes ignored.
// - Bus-clocked counter holds in debug or stop and resumes after.
// - 1 kHz counter clears on debug or stop entry, restarts from zero.
// - Any reset drives the reset pin low 34 cycles then releases it.
// - Pin sampled 38 cycles after release to detect external pin reset.
// - Eight reset sources; all but debug-forced set their own cause bit.
module wdrst_top
  import wdrst_pkg::*;
#(
  parameter int CNT_W = 18,
  parameter int LPO_E1 = 5,
  parameter int LPO_E2 = 8,
  parameter int LPO_E3 = 10,
  parameter int BUS_E1 = 13,
  parameter int BUS_E2 = 16,
  parameter int BUS_E3 = 18
) (
  // Clock and synchronous power-on reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdrst_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset requests from other monitors, one-cycle pulses
  input wire logic illegal_opcode_reset,
  input wire logic illegal_address_reset,
  input wire logic low_voltage_reset,
  input wire logic loss_of_clock_reset,
  input wire logic debug_forced_reset,
  // Low-power modes
  input wire logic debug_mode,
  input wire logic stop_mode,
  // Internal 1 kHz source, asynchronous
  input wire logic lpo_clk_in,
  // Open-drain reset pin
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  // System reset and interrupt
  output logic sys_reset_o,
  output logic irq
);
  import wdrst_pkg::*;

  // Elaboration check of counter sizing
  if (BUS_E3 > CNT_W || LPO_E3 > CNT_W || LPO_E1 < 2 || BUS_E1 < 2)
  begin : g_bad_param
    $error("watchdog exponents do not fit the counter width");
  end

  wdrst_cnt_if cif ();

  wdrst_seq_e seq_q;
  logic [SEQ_CNT_W-1:0] seq_cnt_q;
  logic [CAUSE_W-1:0] cause_q;
  logic [1:0] tsel_q;
  logic clksel_q;
  logic winen_q;
  logic opt1_lock_q;
  logic opt2_lock_q;
  logic armed_q;
  logic lpo_d_q;
  logic lowpow_d_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic lpo_s;
  logic pin_s;
  logic run;
  logic pin_low;
  logic lowpow;
  logic wr;
  logic setup_rd;
  logic mapped;
  logic svc_wr;
  logic is_first;
  logic is_second;
  logic wd_en;
  logic early;
  logic svc_fault;
  logic svc_done;
  logic stray;
  logic opt1_wr;
  logic opt2_wr;
  logic opt_ignored;
  logic trig;
  logic seq_done;
  logic [IRQ_W-1:0] irq_set;

  // Pin and 1 kHz source pass two flops before use
  wdrst_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({lpo_clk_in, reset_pin_i}),
    .q({lpo_s, pin_s})
  );

  wdrst_counter #(
    .CNT_W(CNT_W),
    .LPO_E1(LPO_E1),
    .LPO_E2(LPO_E2),
    .LPO_E3(LPO_E3),
    .BUS_E1(BUS_E1),
    .BUS_E2(BUS_E2),
    .BUS_E3(BUS_E3)
  ) u_counter (
    .clk(clk),
    .rst(rst),
    .cif(cif)
  );

  // Common decode
  assign run = (seq_q == SEQ_RUN);
  assign pin_low = ~pin_s;
  assign lowpow = debug_mode | stop_mode;
  assign wr = psel & penable & pwrite & run;
  assign setup_rd = psel & ~penable;
  assign mapped = (paddr == OFF_CAUSE) || (paddr == OFF_OPT1) || (paddr == OFF_OPT2) ||
    (paddr == OFF_IRQ_STAT) || (paddr == OFF_IRQ_MASK);

  // Service write classification
  assign svc_wr = wr & (paddr == OFF_CAUSE);
  assign is_first = (pwdata == SERVICE_FIRST);
  assign is_second = (pwdata == SERVICE_SECOND);
  assign wd_en = (tsel_q != TSEL_OFF);
  assign early = wd_en & clksel_q & winen_q & ~cif.in_window;
  assign svc_fault = svc_wr & ((~is_first & ~is_second) | early);
  assign svc_done = svc_wr & is_second & armed_q & ~early;
  assign stray = svc_wr & is_second & ~armed_q;

  // Option register writes
  assign opt1_wr = wr & (paddr == OFF_OPT1);
  assign opt2_wr = wr & (paddr == OFF_OPT2);
  assign opt_ignored = (opt1_wr & opt1_lock_q) | (opt2_wr & opt2_lock_q);

  // Counter control
  assign cif.bus_sel = clksel_q;
  assign cif.tsel = tsel_q;
  assign cif.tick = clksel_q ? ~lowpow : (lpo_s & ~lpo_d_q & ~lowpow);
  assign cif.restart = ~run | svc_done | (opt1_wr & ~opt1_lock_q) |
    (opt2_wr & ~opt2_lock_q) | (~clksel_q & lowpow);

  // Any reset source while running starts the pin sequence
  assign trig = run & (pin_low | (cif.timeout & wd_en) | svc_fault | illegal_opcode_reset |
    illegal_address_reset | low_voltage_reset | loss_of_clock_reset |
    debug_forced_reset);

  assign seq_done = (seq_q == SEQ_SETTLE && seq_cnt_q == RST_SAMPLE_CYC - 6'h1 && ~pin_low) ||
    (seq_q == SEQ_HOLD && ~pin_low);

  // Edge trackers for 1 kHz source and low-power entry
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lpo_d_q <= 1'b1;
      lowpow_d_q <= 1'b0;
    end
    else
    begin
      lpo_d_q <= lpo_s;
      lowpow_d_q <= lowpow;
    end
  end

  // Reset pin sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seq_q <= SEQ_DRIVE;
      seq_cnt_q <= '0;
    end
    else
    begin
      case (seq_q)
        SEQ_DRIVE:
        begin
          if (seq_cnt_q == RST_DRIVE_CYC - 6'h1)
          begin
            seq_q <= SEQ_SETTLE;
            seq_cnt_q <= '0;
          end
          else
            seq_cnt_q <= seq_cnt_q + 6'h1;
        end
        SEQ_SETTLE:
        begin
          if (seq_cnt_q == RST_SAMPLE_CYC - 6'h1)
          begin
            seq_q <= pin_low ? SEQ_HOLD : SEQ_RUN;
            seq_cnt_q <= '0;
          end
          else
            seq_cnt_q <= seq_cnt_q + 6'h1;
        end
        SEQ_HOLD:
        begin
          if (~pin_low)
            seq_q <= SEQ_RUN;
        end
        SEQ_RUN:
        begin
          if (trig)
          begin
            seq_q <= SEQ_DRIVE;
            seq_cnt_q <= '0;
          end
        end
        default:
        begin
          seq_q <= SEQ_DRIVE;
          seq_cnt_q <= '0;
        end
      endcase
    end
  end

  // Reset cause, replaced on each new reset
  always_ff @(posedge clk)
  begin
    if (rst)
      cause_q <= 7'h01;
    else if (trig)
    begin
      cause_q <= '0;
      cause_q[CAUSE_WDOG] <= (cif.timeout & wd_en) | svc_fault;
      cause_q[CAUSE_ILLEGAL_OPCODE_RESET] <= illegal_opcode_reset;
      cause_q[CAUSE_ILLEGAL_ADDRESS_RESET] <= illegal_address_reset;
      cause_q[CAUSE_LVD] <= low_voltage_reset;
      cause_q[CAUSE_LOC] <= loss_of_clock_reset;
    end
    else if (seq_q == SEQ_SETTLE && seq_cnt_q == RST_SAMPLE_CYC - 6'h1 && pin_low)
      cause_q[CAUSE_PIN] <= 1'b1;
  end

  // Write-once option bits, back to defaults during every reset
  always_ff @(posedge clk)
  begin
    if (rst || !run)
    begin
      tsel_q <= TSEL_RST;
      clksel_q <= CLKSEL_RST;
      winen_q <= WINEN_RST;
      opt1_lock_q <= 1'b0;
      opt2_lock_q <= 1'b0;
    end
    else
    begin
      if (opt1_wr && !opt1_lock_q)
      begin
        tsel_q <= pwdata[1:0];
        opt1_lock_q <= 1'b1;
      end
      if (opt2_wr && !opt2_lock_q)
      begin
        clksel_q <= pwdata[OPT2_CLKSEL_BIT];
        winen_q <= pwdata[OPT2_WINEN_BIT];
        opt2_lock_q <= 1'b1;
      end
    end
  end

  // Service sequence tracker
  always_ff @(posedge clk)
  begin
    if (rst || !run)
      armed_q <= 1'b0;
    else if (svc_wr)
      armed_q <= is_first & ~early;
  end

  // Interrupt status, set wins over write-one clear
  assign irq_set = {seq_done, stray, opt_ignored, svc_done};
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_stat_q <= '0;
    else if (psel && penable && pwrite && paddr == OFF_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | irq_set;
    else
      irq_stat_q <= irq_stat_q | irq_set;
  end

  // Interrupt mask
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_mask_q <= '0;
    else if (psel && penable && pwrite && paddr == OFF_IRQ_MASK)
      irq_mask_q <= pwdata[IRQ_W-1:0];
  end

  // Read data and error captured in the setup phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end
    else if (setup_rd)
    begin
      pslverr_q <= ~mapped;
      prdata_q <= '0;
      case (paddr)
        OFF_CAUSE: prdata_q <= {25'h0, cause_q};
        OFF_OPT1: prdata_q <= {30'h0, tsel_q};
        OFF_OPT2: prdata_q <= {30'h0, winen_q, clksel_q};
        OFF_IRQ_STAT: prdata_q <= {28'h0, irq_stat_q};
        OFF_IRQ_MASK: prdata_q <= {28'h0, irq_mask_q};
        default: prdata_q <= '0;
      endcase
    end
  end

  // Outputs
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & psel & penable;
  assign pready = 1'b1; // Zero wait states
  assign reset_pin_o = 1'b0; // Open drain, only ever pulls low
  assign reset_pin_oe = (seq_q == SEQ_DRIVE);
  assign sys_reset_o = ~run;
  assign irq = |(irq_stat_q & irq_mask_q);
endmodule : wdrst_top

// ===== test/wdrst_props.sv
// Port-level checker for the watchdog and reset-pin sequencer
module wdrst_props
  import wdrst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdrst_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Reset sources and pin
  input wire logic illegal_opcode_reset,
  input wire logic loss_of_clock_reset,
  input wire logic reset_pin_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe,
  input wire logic sys_reset_o
);
  import wdrst_pkg::*;
  logic [6:0] oe_q;
  logic [6:0] rel_q;
  logic acc;
  logic mapped;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Access phase and address decode
  assign acc = psel && penable;
  assign mapped = paddr inside {OFF_CAUSE, OFF_OPT1, OFF_OPT2, OFF_IRQ_STAT, OFF_IRQ_MASK};
  // Length of the driven phase and of the released phase
  always_ff @(posedge clk)
  begin
    oe_q <= (rst || !reset_pin_oe) ? 7'h00 : oe_q + 7'h01;
    rel_q <= (rst || reset_pin_oe || !sys_reset_o) ? 7'h00 : rel_q + 7'h01;
  end
  sequence s_bad_wr;
    acc && pwrite && paddr == OFF_CAUSE && !sys_reset_o &&
      pwdata != SERVICE_FIRST && pwdata != SERVICE_SECOND;
  endsequence
  sequence s_pin_low;
    !reset_pin_i [*6];
  endsequence
  property p_bad_wr;
    s_bad_wr |=> sys_reset_o && reset_pin_oe;
  endproperty
  property p_src;
    (illegal_opcode_reset || loss_of_clock_reset) && !sys_reset_o |=> sys_reset_o;
  endproperty
  property p_oe_len;
    $fell(reset_pin_oe) |-> oe_q == 7'h22;
  endproperty
  property p_settle;
    $fell(sys_reset_o) |-> rel_q >= 7'h26 && !reset_pin_oe;
  endproperty
  property p_drive;
    reset_pin_oe |-> !reset_pin_o && sys_reset_o;
  endproperty
  property p_rise;
    $rose(sys_reset_o) |-> $rose(reset_pin_oe);
  endproperty
  property p_ready;
    acc |-> pready;
  endproperty
  property p_err;
    acc |-> pslverr == !mapped;
  endproperty
  property p_pin;
    s_pin_low |-> sys_reset_o;
  endproperty
  a_bad_wr: assert property (p_bad_wr) else $error("bad service value no reset");
  a_src: assert property (p_src) else $error("reset source ignored");
  a_oe_len: assert property (p_oe_len) else $error("pin drive length wrong");
  a_settle: assert property (p_settle) else $error("release phase too short");
  a_drive: assert property (p_drive) else $error("pin not driven low");
  a_rise: assert property (p_rise) else $error("reset without pin drive");
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_err: assert property (p_err) else $error("pslverr wrong for address");
  a_pin: assert property (p_pin) else $error("low pin did not reset");
endmodule : wdrst_props

bind wdrst_top wdrst_props i_props (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .illegal_opcode_reset, .loss_of_clock_reset, .reset_pin_i,
  .reset_pin_o, .reset_pin_oe, .sys_reset_o);

// ===== test/wdrst_line.sv
// Reset line with pull-up and a shortened stand-in for the slow clock
module wdrst_line (
  // Line drivers
  input wire logic pin_oe,
  input wire logic pin_o,
  input wire logic ext_low,
  // Resolved line and slow clock
  output logic pin,
  output logic lpo
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-up unless someone pulls low
  assign pin = ((pin_oe && !pin_o) || ext_low) ? 1'b0 : 1'b1;
  // Slow clock, unrelated in phase to clk
  initial
  begin
    lpo = 1'b0;
    forever #10030 lpo = ~lpo;
  end
endmodule : wdrst_line

// ===== test/wdrst_tb_top.sv
// Self-checking bench for the watchdog and reset-pin sequencer
module wdrst_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wdrst_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, pv;
  logic [4:0] src;
  logic stop, dbg, ext_low, pin, lpo, pin_o, pin_oe, sys_rst, irq;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed;
  // Device with shortened timeouts
  wdrst_top #(.BUS_E1(4), .BUS_E2(5), .BUS_E3(6), .LPO_E3(4)) i_dut (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .illegal_opcode_reset(src[0]), .illegal_address_reset(src[1]),
    .low_voltage_reset(src[2]), .loss_of_clock_reset(src[3]), .debug_forced_reset(src[4]),
    .debug_mode(dbg), .stop_mode(stop), .lpo_clk_in(lpo), .reset_pin_i(pin),
    .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .sys_reset_o(sys_rst), .irq);
  wdrst_line i_line (.pin_oe, .pin_o, .ext_low, .pin, .lpo);
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk32
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the slave; only the hang guard ends a stuck transfer
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_sys(input logic lvl, input int mx);
    int n;
    n = 0;
    while (sys_rst !== lvl && n < mx)
    begin
      @(posedge clk);
      n++;
    end
    chk32("sys_reset_o", {31'h0, lvl}, {31'h0, sys_rst});
  endtask : wait_sys
  task automatic expect_reset(input int mx, input logic [31:0] cause);
    wait_sys(1'b1, mx);
    wait_sys(1'b0, 200);
    apb(1'b0, OFF_CAUSE, 32'h0);
    chk32("cause", cause, rd);
  endtask : expect_reset
  // Main sequence
  initial
  begin
    seed = 37;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src = 5'h00;
    stop = 1'b0;
    dbg = 1'b0;
    ext_low = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    expect_reset(10, 32'h01);
    apb(1'b0, OFF_OPT1, 32'h0);
    chk32("opt1", {30'h0, TSEL_RST}, rd);
    apb(1'b0, OFF_OPT2, 32'h0);
    chk32("opt2", 32'h0, rd);
    apb(1'b0, 8'h14 + APB_AW'(($random(seed) & 7) << 2), 32'h0);
    chk32("pslverr", 32'h1, {31'h0, er});
    apb(1'b1, OFF_CAUSE, SERVICE_FIRST);
    apb(1'b1, OFF_CAUSE, SERVICE_SECOND);
    apb(1'b0, OFF_CAUSE, 32'h0);
    chk32("cause", 32'h01, rd);
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    chk32("stat", 32'h1, rd & 32'h1);
    chk32("irq", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk32("irq", 32'h0, {31'h0, irq});
    apb(1'b1, OFF_CAUSE, SERVICE_SECOND);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    chk32("stat", 32'h4, rd & 32'h4);
    // Bus clock, shortest timeout, options locked
    apb(1'b1, OFF_OPT2, 32'h1);
    apb(1'b1, OFF_OPT1, 32'h1);
    apb(1'b1, OFF_OPT1, 32'h2);
    apb(1'b0, OFF_OPT1, 32'h0);
    chk32("opt1", 32'h1, rd);
    repeat (3)
    begin
      apb(1'b1, OFF_CAUSE, SERVICE_FIRST);
      apb(1'b1, OFF_CAUSE, SERVICE_SECOND);
    end
    chk32("sys_reset_o", 32'h0, {31'h0, sys_rst});
    expect_reset(40, 32'h04);
    apb(1'b0, OFF_OPT1, 32'h0);
    chk32("opt1", 32'h3, rd);
    // Early service in window mode
    apb(1'b1, OFF_OPT2, 32'h3);
    apb(1'b1, OFF_OPT1, 32'h3);
    apb(1'b1, OFF_CAUSE, SERVICE_FIRST);
    expect_reset(5, 32'h04);
    apb(1'b1, OFF_OPT2, 32'h2);
    apb(1'b1, OFF_CAUSE, SERVICE_FIRST);
    apb(1'b1, OFF_CAUSE, SERVICE_SECOND);
    chk32("sys_reset_o", 32'h0, {31'h0, sys_rst});
    pv = $random(seed) | 32'h100;
    apb(1'b1, OFF_CAUSE, pv);
    expect_reset(5, 32'h04);
    // Bus-clocked counter holds while debug is active, then resumes
    apb(1'b1, OFF_OPT2, 32'h1);
    apb(1'b1, OFF_OPT1, 32'h1);
    dbg <= 1'b1;
    repeat (40 + ($random(seed) & 31)) @(posedge clk);
    chk32("sys_reset_o", 32'h0, {31'h0, sys_rst});
    dbg <= 1'b0;
    expect_reset(40, 32'h04);
    // Every reset source in turn
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      src <= 5'h01 << i;
      @(posedge clk);
      src <= 5'h00;
      expect_reset(5, i < 4 ? 32'h08 << i : 32'h0);
    end
    ext_low <= 1'b1;
    repeat (100) @(posedge clk);
    ext_low <= 1'b0;
    expect_reset(5, 32'h02);
    // 1 kHz counter held at zero in stop, then default timeout
    stop <= 1'b1;
    repeat (4000) @(posedge clk);
    chk32("sys_reset_o", 32'h0, {31'h0, sys_rst});
    stop <= 1'b0;
    expect_reset(3500, 32'h04);
    wrap_up();
  end
endmodule : wdrst_tb_top
